// file: verilog/sbus_irq_pkg.sv
package sbus_irq_pkg;

   // ----------------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------------
   localparam int NUM_FLAGS = 12;
   localparam int CNT_W     = 8;
   localparam int ADR_W     = 4;

   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [3:0] ENABLE_OFS = 4'h0;
   localparam logic [3:0] FLAGS_OFS  = 4'h4;
   localparam logic [3:0] LINES_OFS  = 4'h8;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [NUM_FLAGS-1:0] ENABLE_RST = 12'h000;
   localparam logic [NUM_FLAGS-1:0] FLAGS_RST  = 12'h000;

   // ----------------------------------------------------------------------
   // flag bit positions
   // ----------------------------------------------------------------------
   localparam int TIMING_BIT   = 0;
   localparam int PARITY_BIT   = 1;
   localparam int NACK_BIT     = 2;
   localparam int UNDERRUN_BIT = 3;
   localparam int OVERRUN_BIT  = 4;
   localparam int WRITE_BIT    = 5;
   localparam int START_BIT    = 6;
   localparam int STATUS_BIT   = 7;
   localparam int ENDCOMM_BIT  = 8;
   localparam int ENDFRAME_BIT = 9;
   localparam int TXREQ_BIT    = 10;
   localparam int RXREQ_BIT    = 11;

   // ----------------------------------------------------------------------
   // line status bit positions
   // ----------------------------------------------------------------------
   localparam int DATA_LINE_BIT  = 0;
   localparam int ERR_LINE_BIT   = 1;
   localparam int STAT_LINE_BIT  = 2;
   localparam int COMB_LINE_BIT  = 3;
   localparam int COMM_ERR_BIT   = 4;

   // ----------------------------------------------------------------------
   // frame field currently on the bus
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      field_idle,
      field_address,
      field_control,
      field_length,
      field_data
   } field_t;

   // ----------------------------------------------------------------------
   // event carrier from the protocol engine
   // ----------------------------------------------------------------------
   typedef struct packed {
      field_t             field;
      logic               is_master;
      logic               is_rx;
      logic               is_tx;
      logic               broadcast;
      logic               timing_bad;
      logic               parity_bad;
      logic               nack_seen;
      logic               underrun;
      logic               overrun;
      logic               write_clash;
      logic               addr_done;
      logic               arb_lost;
      logic               master_req;
      logic               slave_selected;
      logic               ctrl_done;
      logic               nack_in_ctrl;
      logic               tx_load;
      logic               tx_last;
      logic               rx_byte_done;
      logic               rx_byte_err;
      logic [CNT_W-1:0]   remaining_cnt;
      logic [CNT_W-1:0]   frame_cnt;
   } evt_t;

   // ----------------------------------------------------------------------
   // request lines toward interrupt and dma controllers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic data_request_irq;
      logic error_irq;
      logic status_irq;
      logic combined_event_irq;
      logic dma_tx_req;
      logic dma_rx_req;
   } req_t;

endpackage : sbus_irq_pkg

// file: verilog/sticky_bits.sv
`timescale 1ns/1ps
module sticky_bits #(
   parameter int W = 12
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // set and clear
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clr_i,
   // stored bits
   output logic      [W-1:0] q_o
);

   // ----------------------------------------------------------------------
   // set has priority so a same-cycle event survives a clear
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= '0;
      end else begin
         q_o <= (q_o & ~clr_i) | set_i;
      end
   end

endmodule : sticky_bits

// file: verilog/serial_bus_interrupt_sources.sv
// Function
// - comm error flag is the OR of the six error sources
// - parity in non-data individual or any broadcast field; nack in non-data individual field
// - master losing arbitration with pending request always raises start
// - slave raises start only when it is the selected slave
// - slave raises status flag in control field regardless of enable
// - nack returned in control field also raises status flag
// - remaining counter reaching zero in data field sets end of comm
// - frame counter reaching zero in data field sets end of frame
// - transmit write request after byte moves to shift register
// - no transmit write request when last byte moves
// - receive read request only after error-free data byte
// - requests drive both interrupt lines and dma triggers
// - data request line is OR of transmit and receive requests
// - error line is OR of the six error sources
// - status line is OR of start, status, end comm, end frame
// - combined line is OR of status line and error line
`timescale 1ns/1ps
module serial_bus_interrupt_sources #(
   parameter int CNT_W = sbus_irq_pkg::CNT_W
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // wishbone slave
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   input  wire logic                  we_i,
   input  wire logic [3:0]            adr_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic [31:0]           dat_i,
   output logic      [31:0]           dat_o,
   output logic                       ack_o,
   // protocol engine events
   input  wire sbus_irq_pkg::evt_t    evt_i,
   // dma acknowledges
   input  wire logic                  dma_tx_ack_i,
   input  wire logic                  dma_rx_ack_i,
   // request lines
   output sbus_irq_pkg::req_t         req_o,
   output logic                       comm_error_flag_o
);

   localparam int NF = sbus_irq_pkg::NUM_FLAGS;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [NF-1:0]    enable_reg;
   logic [NF-1:0]    flags_q;
   logic [NF-1:0]    set_c;
   logic [NF-1:0]    clr_c;
   logic [NF-1:0]    live_c;
   logic [CNT_W-1:0] remain_prev_reg;
   logic [CNT_W-1:0] frame_prev_reg;
   logic             in_data_c;
   logic             err_any_c;
   logic             stat_any_c;
   logic             data_any_c;
   logic             wr_c;
   logic             rd_c;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [3:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign wr_c = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && sel_i[1];
   assign rd_c = cyc_i && stb_i && !we_i && !ack_o;

   // ----------------------------------------------------------------------
   // event qualification
   // ----------------------------------------------------------------------
   assign in_data_c = (evt_i.field == sbus_irq_pkg::field_data);

   always_comb begin
      set_c = '0;
      set_c[sbus_irq_pkg::TIMING_BIT] = evt_i.timing_bad;
      set_c[sbus_irq_pkg::PARITY_BIT] = evt_i.is_rx && evt_i.parity_bad &&
         (evt_i.broadcast || !in_data_c);
      set_c[sbus_irq_pkg::NACK_BIT] = evt_i.nack_seen && !in_data_c &&
         !evt_i.broadcast;
      set_c[sbus_irq_pkg::UNDERRUN_BIT] = evt_i.is_tx && in_data_c &&
         evt_i.underrun;
      set_c[sbus_irq_pkg::WRITE_BIT] = evt_i.is_tx && in_data_c &&
         evt_i.write_clash;
      set_c[sbus_irq_pkg::OVERRUN_BIT] = evt_i.is_rx && in_data_c &&
         evt_i.broadcast && evt_i.overrun;
      set_c[sbus_irq_pkg::START_BIT] = evt_i.addr_done &&
         ((evt_i.is_master && evt_i.arb_lost && evt_i.master_req) ||
          (evt_i.is_master && !evt_i.arb_lost) ||
          (!evt_i.is_master && evt_i.slave_selected));
      set_c[sbus_irq_pkg::STATUS_BIT] = evt_i.nack_in_ctrl ||
         (!evt_i.is_master && evt_i.ctrl_done);
      set_c[sbus_irq_pkg::ENDCOMM_BIT] = in_data_c &&
         (evt_i.remaining_cnt == '0) && (remain_prev_reg != '0);
      set_c[sbus_irq_pkg::ENDFRAME_BIT] = in_data_c &&
         (evt_i.frame_cnt == '0) && (frame_prev_reg != '0);
      set_c[sbus_irq_pkg::TXREQ_BIT] = evt_i.is_tx && in_data_c &&
         evt_i.tx_load && !evt_i.tx_last;
      set_c[sbus_irq_pkg::RXREQ_BIT] = evt_i.is_rx && in_data_c &&
         evt_i.rx_byte_done && !evt_i.rx_byte_err;
   end

   // counters seen one cycle back to catch the step to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         remain_prev_reg <= '0;
         frame_prev_reg  <= '0;
      end else begin
         remain_prev_reg <= evt_i.remaining_cnt;
         frame_prev_reg  <= evt_i.frame_cnt;
      end
   end

   // ----------------------------------------------------------------------
   // sticky flags, cleared by write-one or dma acknowledge
   // ----------------------------------------------------------------------
   always_comb begin
      clr_c = '0;
      if (wr_c && hit(adr_i, sbus_irq_pkg::FLAGS_OFS)) begin
         clr_c = dat_i[NF-1:0];
      end
      clr_c[sbus_irq_pkg::TXREQ_BIT] = clr_c[sbus_irq_pkg::TXREQ_BIT] ||
         dma_tx_ack_i;
      clr_c[sbus_irq_pkg::RXREQ_BIT] = clr_c[sbus_irq_pkg::RXREQ_BIT] ||
         dma_rx_ack_i;
   end

   sticky_bits #(
      .W     (NF)
   ) u_flags (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .set_i (set_c),
      .clr_i (clr_c),
      .q_o   (flags_q)
   );

   // ----------------------------------------------------------------------
   // enable register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_reg <= sbus_irq_pkg::ENABLE_RST;
      end else if (wr_c && hit(adr_i, sbus_irq_pkg::ENABLE_OFS)) begin
         enable_reg <= dat_i[NF-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // line combining
   // ----------------------------------------------------------------------
   // masking before the OR keeps a disabled source from waking the cpu
   assign live_c     = flags_q & enable_reg;
   assign err_any_c  = |live_c[sbus_irq_pkg::WRITE_BIT:0];
   assign stat_any_c = |live_c[sbus_irq_pkg::ENDFRAME_BIT:
                               sbus_irq_pkg::START_BIT];
   assign data_any_c = live_c[sbus_irq_pkg::TXREQ_BIT] ||
                       live_c[sbus_irq_pkg::RXREQ_BIT];

   // one cycle of latency buys glitch-free registered lines
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_o             <= '0;
         comm_error_flag_o <= 1'b0;
      end else begin
         req_o.data_request_irq   <= data_any_c;
         req_o.error_irq          <= err_any_c;
         req_o.status_irq         <= stat_any_c;
         req_o.combined_event_irq <= stat_any_c || err_any_c;
         req_o.dma_tx_req <= live_c[sbus_irq_pkg::TXREQ_BIT];
         req_o.dma_rx_req <= live_c[sbus_irq_pkg::RXREQ_BIT];
         comm_error_flag_o <=
            |flags_q[sbus_irq_pkg::WRITE_BIT:0];
      end
   end

   // ----------------------------------------------------------------------
   // wishbone answer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_c) begin
         dat_o <= 32'h0000_0000;
         case (adr_i)
            sbus_irq_pkg::ENABLE_OFS: dat_o[NF-1:0] <= enable_reg;
            sbus_irq_pkg::FLAGS_OFS:  dat_o[NF-1:0] <= flags_q;
            sbus_irq_pkg::LINES_OFS: begin
               dat_o[sbus_irq_pkg::DATA_LINE_BIT] <= req_o.data_request_irq;
               dat_o[sbus_irq_pkg::ERR_LINE_BIT]  <= req_o.error_irq;
               dat_o[sbus_irq_pkg::STAT_LINE_BIT] <= req_o.status_irq;
               dat_o[sbus_irq_pkg::COMB_LINE_BIT] <=
                  req_o.combined_event_irq;
               dat_o[sbus_irq_pkg::COMM_ERR_BIT]  <= comm_error_flag_o;
            end
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_comm_err;
      ##1 comm_error_flag_o == $past(|flags_q[5:0]);
   endproperty
   a_comm_err: assert property (p_comm_err)
      else $error("comm error flag not OR of sources");

   property p_parity;
      evt_i.is_rx && evt_i.parity_bad && (evt_i.broadcast || !in_data_c)
         |=> flags_q[1];
   endproperty
   a_parity: assert property (p_parity)
      else $error("parity error not flagged");

   property p_start_master;
      evt_i.addr_done && evt_i.is_master && evt_i.arb_lost &&
         evt_i.master_req |=> flags_q[6];
   endproperty
   a_start_master: assert property (p_start_master)
      else $error("start missing after lost arbitration");

   property p_start_slave;
      evt_i.addr_done && !evt_i.is_master && !evt_i.slave_selected
         |=> !$rose(flags_q[6]);
   endproperty
   a_start_slave: assert property (p_start_slave)
      else $error("start raised for unselected slave");

   property p_status;
      (!evt_i.is_master && evt_i.ctrl_done) || evt_i.nack_in_ctrl
         |=> flags_q[7];
   endproperty
   a_status: assert property (p_status)
      else $error("status flag not raised");

   property p_endcomm;
      in_data_c && evt_i.remaining_cnt == '0 && remain_prev_reg != '0
         |=> flags_q[8];
   endproperty
   a_endcomm: assert property (p_endcomm)
      else $error("end of comm not set");

   sequence s_last_load;
      evt_i.tx_load && evt_i.tx_last && !flags_q[10];
   endsequence
   property p_tx_last;
      s_last_load |=> !flags_q[10];
   endproperty
   a_tx_last: assert property (p_tx_last)
      else $error("write request on last byte");

   property p_tx_req;
      evt_i.is_tx && in_data_c && evt_i.tx_load && !evt_i.tx_last
         |=> flags_q[10];
   endproperty
   a_tx_req: assert property (p_tx_req)
      else $error("write request missing");

   property p_rx_err;
      evt_i.rx_byte_done && evt_i.rx_byte_err && !flags_q[11]
         |=> !flags_q[11];
   endproperty
   a_rx_err: assert property (p_rx_err)
      else $error("read request after bad byte");

   sequence s_flag_live;
      live_c[11] || live_c[10];
   endsequence
   property p_data_line;
      s_flag_live |=> req_o.data_request_irq;
   endproperty
   a_data_line: assert property (p_data_line)
      else $error("data request line not raised");

   property p_comb_line;
      req_o.combined_event_irq == (req_o.status_irq || req_o.error_irq);
   endproperty
   a_comb_line: assert property (p_comb_line)
      else $error("combined line mismatch");

   property p_nack;
      evt_i.nack_seen && !in_data_c && !evt_i.broadcast
         |=> flags_q[sbus_irq_pkg::NACK_BIT];
   endproperty
   a_nack: assert property (p_nack)
      else $error("nack error not flagged");

   property p_underrun;
      evt_i.is_tx && in_data_c && evt_i.underrun
         |=> flags_q[sbus_irq_pkg::UNDERRUN_BIT];
   endproperty
   a_underrun: assert property (p_underrun)
      else $error("underrun not flagged");

   property p_endframe;
      in_data_c && evt_i.frame_cnt == '0 && frame_prev_reg != '0
         |=> flags_q[sbus_irq_pkg::ENDFRAME_BIT];
   endproperty
   a_endframe: assert property (p_endframe)
      else $error("end of frame not set");

   property p_err_line;
      ##1 req_o.error_irq ==
         $past(|(flags_q[5:0] & enable_reg[5:0]));
   endproperty
   a_err_line: assert property (p_err_line)
      else $error("error line not OR of sources");

   property p_stat_line;
      ##1 req_o.status_irq ==
         $past(|(flags_q[9:6] & enable_reg[9:6]));
   endproperty
   a_stat_line: assert property (p_stat_line)
      else $error("status line not OR of flags");

   property p_dma_tx;
      ##1 req_o.dma_tx_req ==
         $past(flags_q[10] && enable_reg[10]);
   endproperty
   a_dma_tx: assert property (p_dma_tx)
      else $error("dma transmit trigger mismatch");

   property p_masked;
      enable_reg == '0
         |=> !req_o.status_irq && !req_o.error_irq;
   endproperty
   a_masked: assert property (p_masked)
      else $error("disabled source raised a line");

endmodule : serial_bus_interrupt_sources

// file: verif/irq_dma_partner.sv
`timescale 1ns/1ps
module irq_dma_partner (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // request lines and control
   input  wire sbus_irq_pkg::req_t req_i,
   input  wire logic               ack_en_i,
   input  wire logic [3:0]         dly_i,
   // dma acknowledges and counts
   output logic                    dma_tx_ack_o,
   output logic                    dma_rx_ack_o,
   output int                      tx_cnt_o,
   output int                      rx_cnt_o
);
   // ---------------------------------------------------------------
   // dma channels, one ack per request after dly_i cycles
   // ---------------------------------------------------------------
   initial begin
      dma_tx_ack_o = 1'b0;
      tx_cnt_o     = 0;
      forever begin
         @(posedge clk_i);
         if (ack_en_i && !rst_i && req_i.dma_tx_req === 1'b1) begin
            repeat (dly_i) @(posedge clk_i);
            dma_tx_ack_o <= 1'b1;
            @(posedge clk_i);
            dma_tx_ack_o <= 1'b0;
            tx_cnt_o <= tx_cnt_o + 1;
            // line drops two cycles after ack: no second ack
            repeat (3) @(posedge clk_i);
         end
      end
   end
   initial begin
      dma_rx_ack_o = 1'b0;
      rx_cnt_o     = 0;
      forever begin
         @(posedge clk_i);
         if (ack_en_i && !rst_i && req_i.dma_rx_req === 1'b1) begin
            repeat (dly_i) @(posedge clk_i);
            dma_rx_ack_o <= 1'b1;
            @(posedge clk_i);
            dma_rx_ack_o <= 1'b0;
            rx_cnt_o <= rx_cnt_o + 1;
            repeat (3) @(posedge clk_i);
         end
      end
   end
endmodule : irq_dma_partner

// file: verif/serial_bus_interrupt_sources_tb.sv
`timescale 1ns/1ps
module serial_bus_interrupt_sources_tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic               clk_i;
   logic               rst_i;
   logic               cyc;
   logic               stb;
   logic               we;
   logic [3:0]         adr;
   logic [3:0]         sel;
   logic [31:0]        dat_w;
   logic [31:0]        dat_r;
   logic               ack;
   sbus_irq_pkg::evt_t evt;
   sbus_irq_pkg::evt_t base;
   sbus_irq_pkg::req_t req;
   logic               comm_err;
   logic               tx_ack;
   logic               rx_ack;
   logic               ack_en;
   logic [3:0]         dly;
   int                 tx_cnt;
   int                 rx_cnt;
   int                 mismatches;
   int                 samples_checked;
   int                 fl;
   int                 en;

   serial_bus_interrupt_sources u_serial_bus_interrupt_sources (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .evt_i(evt), .dma_tx_ack_i(tx_ack), .dma_rx_ack_i(rx_ack),
      .req_o(req), .comm_error_flag_o(comm_err));
   irq_dma_partner u_irq_dma_partner (
      .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .ack_en_i(ack_en),
      .dly_i(dly), .dma_tx_ack_o(tx_ack), .dma_rx_ack_o(rx_ack),
      .tx_cnt_o(tx_cnt), .rx_cnt_o(rx_cnt));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // model and checks
   // ---------------------------------------------------------------
   task automatic test_done();
      if (mismatches == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   function automatic sbus_irq_pkg::evt_t ev(sbus_irq_pkg::field_t f,
                                             logic [3:0] m);
      ev = '0;
      ev.field = f;
      {ev.is_master, ev.is_rx, ev.is_tx, ev.broadcast} = m;
      // counters idle nonzero so a drop to zero is an edge
      ev.remaining_cnt = 8'h01;
      ev.frame_cnt = 8'h01;
   endfunction : ev

   // {data, err, status, combined, dma tx, dma rx, comm error}
   function automatic logic [6:0] exp_out();
      int   m;
      logic e;
      logic s;
      m = fl & en;
      e = (m & 32'h3f) != 0;
      s = (m & 32'h3c0) != 0;
      return {(m & 32'hc00) != 0, e, s, e | s, m[10], m[11],
              (fl & 32'h3f) != 0};
   endfunction : exp_out

   task automatic chk_reg(input string nm, input logic [31:0] x,
                          input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask : chk_reg

   task automatic chk_req();
      logic [6:0] x;
      x = exp_out();
      samples_checked++;
      if ({req, comm_err} !== x) begin
         mismatches++;
         $display("Error req lines expected %h seen %h", x, {req, comm_err});
      end
   endtask : chk_req

   // ---------------------------------------------------------------
   // wishbone master
   // ---------------------------------------------------------------
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= d;
      sel   <= s;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         mismatches++;
         $display("Error bus ack expected 1 seen 0");
         test_done();
      end else begin
         q = dat_r;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask : wb

   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic [31:0] q;
      wb(1'b1, a, d, s, q);
   endtask : wr

   task automatic rd(input logic [3:0] a, input string nm,
                     input logic [31:0] x);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hf, q);
      chk_reg(nm, x, q);
   endtask : rd

   task automatic check_all();
      logic [6:0] o;
      o = exp_out();
      rd(sbus_irq_pkg::FLAGS_OFS, "flags", 32'(fl));
      rd(sbus_irq_pkg::LINES_OFS, "lines",
         {27'h0, o[0], o[3], o[4], o[5], o[6]});
      chk_req();
   endtask : check_all

   // one event cycle, check, then clear all flags by w1c
   task automatic hit(input sbus_irq_pkg::evt_t e, input int b);
      @(posedge clk_i);
      evt <= e;
      @(posedge clk_i);
      evt <= base;
      if (b >= 0)
         fl |= 1 << b;
      repeat (2) @(posedge clk_i);
      check_all();
      wr(sbus_irq_pkg::FLAGS_OFS, 32'hfff, 4'hf);
      fl = 0;
      repeat (2) @(posedge clk_i);
      chk_req();
   endtask : hit

   task automatic run_cases();
      sbus_irq_pkg::evt_t   e;
      sbus_irq_pkg::field_t a;
      sbus_irq_pkg::field_t c;
      sbus_irq_pkg::field_t d;
      a = sbus_irq_pkg::field_address;
      c = sbus_irq_pkg::field_control;
      d = sbus_irq_pkg::field_data;
      e = ev(d, 4'h4);
      e.timing_bad = 1;
      hit(e, sbus_irq_pkg::TIMING_BIT);
      e = ev(a, 4'h4);
      e.parity_bad = 1;
      hit(e, sbus_irq_pkg::PARITY_BIT);
      e.field = d;
      hit(e, -1);
      e.broadcast = 1;
      hit(e, sbus_irq_pkg::PARITY_BIT);
      e = ev(c, 4'h4);
      e.nack_seen = 1;
      hit(e, sbus_irq_pkg::NACK_BIT);
      e = ev(d, 4'h2);
      e.underrun = 1;
      hit(e, sbus_irq_pkg::UNDERRUN_BIT);
      e = ev(d, 4'h5);
      e.overrun = 1;
      hit(e, sbus_irq_pkg::OVERRUN_BIT);
      e = ev(d, 4'h2);
      e.write_clash = 1;
      hit(e, sbus_irq_pkg::WRITE_BIT);
      e = ev(a, 4'h8);
      e.addr_done = 1;
      hit(e, sbus_irq_pkg::START_BIT);
      e.arb_lost = 1;
      e.master_req = 1;
      hit(e, sbus_irq_pkg::START_BIT);
      e = ev(a, 4'h4);
      e.addr_done = 1;
      hit(e, -1);
      e.slave_selected = 1;
      hit(e, sbus_irq_pkg::START_BIT);
      e = ev(c, 4'h2);
      e.ctrl_done = 1;
      hit(e, sbus_irq_pkg::STATUS_BIT);
      e = ev(c, 4'h8);
      e.nack_in_ctrl = 1;
      hit(e, sbus_irq_pkg::STATUS_BIT);
      e = ev(d, 4'h2);
      e.remaining_cnt = 0;
      hit(e, sbus_irq_pkg::ENDCOMM_BIT);
      e = ev(d, 4'h4);
      e.frame_cnt = 0;
      hit(e, sbus_irq_pkg::ENDFRAME_BIT);
      e = ev(d, 4'h2);
      e.tx_load = 1;
      hit(e, sbus_irq_pkg::TXREQ_BIT);
      e.tx_last = 1;
      hit(e, -1);
      e = ev(d, 4'h4);
      e.rx_byte_done = 1;
      hit(e, sbus_irq_pkg::RXREQ_BIT);
      e.rx_byte_err = 1;
      hit(e, -1);
   endtask : run_cases

   // event served by the dma partner; w = 256 for tx, 1 for rx
   task automatic dma(input sbus_irq_pkg::evt_t e, input int w);
      int c0;
      int n;
      c0 = tx_cnt * 256 + rx_cnt;
      @(posedge clk_i);
      evt <= e;
      @(posedge clk_i);
      evt <= base;
      n = 0;
      while (tx_cnt * 256 + rx_cnt == c0 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      chk_reg("dma acks", c0 + w, tx_cnt * 256 + rx_cnt);
      if (n >= 50)
         test_done();
      repeat (3) @(posedge clk_i);
      check_all();
   endtask : dma

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      sbus_irq_pkg::evt_t e;
      mismatches = 0;
      samples_checked = 0;
      fl = 0;
      en = 0;
      rst_i = 1'b1;
      {cyc, stb, we, adr, sel, dat_w} = '0;
      base = ev(sbus_irq_pkg::field_idle, 4'h0);
      evt = base;
      ack_en = 1'b0;
      dly = 4'h0;
      void'($urandom(32'hed35));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(sbus_irq_pkg::ENABLE_OFS, "enable", 32'(sbus_irq_pkg::ENABLE_RST));
      rd(sbus_irq_pkg::FLAGS_OFS, "flags", 32'(sbus_irq_pkg::FLAGS_RST));
      rd(sbus_irq_pkg::LINES_OFS, "lines", 32'h0);
      wr(4'hc, 32'hffffffff, 4'hf);
      rd(4'hc, "unmapped", 32'h0);
      wr(sbus_irq_pkg::ENABLE_OFS, 32'hfff, 4'h0);
      rd(sbus_irq_pkg::ENABLE_OFS, "enable no sel", 32'h0);
      // masked, random, then full enable
      for (int p = 0; p < 3; p++) begin
         en = p == 0 ? 0 : p == 1 ? int'($urandom & 32'hfff) : 32'hfff;
         wr(sbus_irq_pkg::ENABLE_OFS, 32'(en), 4'hf);
         rd(sbus_irq_pkg::ENABLE_OFS, "enable", 32'(en));
         run_cases();
      end
      ack_en <= 1'b1;
      e = ev(sbus_irq_pkg::field_data, 4'h2);
      e.tx_load = 1;
      dma(e, 256);
      dly <= 4'h5;
      e = ev(sbus_irq_pkg::field_data, 4'h4);
      e.rx_byte_done = 1;
      e.remaining_cnt = 0;
      fl = 1 << sbus_irq_pkg::ENDCOMM_BIT;
      dma(e, 1);
      test_done();
   end
endmodule : serial_bus_interrupt_sources_tb
